/* File: shared/hcs_cfg.svh */
`ifndef HCS_CFG_SVH
`define HCS_CFG_SVH
// Register byte addresses
`define HCS_ADDR_CTRL2   2'h0
`define HCS_ADDR_STATUS  2'h1
`define HCS_ADDR_BUF     2'h2
`define HCS_ADDR_RELOAD  2'h3
// Second control register fields
`define HCS_C_START      0
`define HCS_C_RSTART     1
`define HCS_C_RCV        3
`define HCS_C_ACKREQ     4
`define HCS_C_ACKVAL     5
`define HCS_REQ_MASK     5'h1f
// Status register fields
`define HCS_S_WRITE_COLLISION_FLAG       0
`define HCS_S_BCOL       1
`define HCS_S_EVENT      2
`define HCS_S_SSEEN      3
`define HCS_S_ACKSTAT    4
`define HCS_S_BUSY       5
// Reset values
`define HCS_RELOAD_RST   8'h04
// Bits per transfer: byte plus returned acknowledge, byte, ack sequence
`define HCS_TX_BITS      4'h9
`define HCS_RX_BITS      4'h8
`define HCS_ACK_BITS     4'h1
`endif

/* File: shared/hcs_pkg.sv */
package hcs_pkg;
  typedef enum logic [1:0] {
    HCS_M_TX,
    HCS_M_RX,
    HCS_M_ACK
  } hcs_mode_t;
endpackage

/* File: core/hcs_sequencer.sv */
`timescale 1ns/1ps
`include "hcs_cfg.svh"
// Contract
// - Transfers end with Stop or Repeated Start (the sequencer generates no Stop); bus stays held after Repeated Start.
// - Host transmit sends address byte with read/write bit zero.
// - Host receive starts with address byte carrying read/write bit one.
// - Bytes are eight bits; acknowledge follows every byte.
// - Baud generator pauses while clock released, reloads once clock sampled high.
// - Clock high phase lasts at least one full baud rollover.
// - Buffer write while busy sets write collision, buffer unchanged.
// - Low five request bits ignored until pending Start completes.
// - Start request with both lines high reloads baud generator.
// - On timeout with lines high, data low, start-seen set, reload.
// - Second timeout clears start request, halts generator, data stays low.
// - Lines low at start or clock low early: bus collision, abort.
// - Repeated Start request honoured only when sequencer idle.
// - Repeated Start: clock low, release data one period, release clock if data high.
// - Both high one period, data low one period, clock low, request cleared.
// - Start-seen on detected Start; event flag only after baud timeout.
// - Repeated Start collision: data low at clock rise or clock falls early.
// - Ack sequence drives clock low and presents ack value; software sets value first.
// - Ack: one period low, release, one period high, clock low, back to idle.
// - Buffer write during ack sequence sets write collision.
// - Start detection suspended while generating a Start, not a Repeated Start; event flag raised at request clear.
module hcs_sequencer
  import hcs_pkg::*;
#(
  parameter int BW = 8
) (
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic [1:0]    addr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [7:0]    rdata_o,
  input  wire logic          scl_i,
  output logic               scl_o,
  output logic               scl_oe_o,
  input  wire logic          sda_i,
  output logic               sda_o,
  output logic               sda_oe_o
);

  typedef enum logic [3:0] {
    HCS_IDLE, HCS_ST_WAIT, HCS_ST_HOLD,
    HCS_RS_LOW, HCS_RS_SDA, HCS_RS_SCLH, HCS_RS_HIGH, HCS_RS_SDAL,
    HCS_B_LOW, HCS_B_REL, HCS_B_HIGH
  } hcs_state_t;

  hcs_state_t  state_r;
  hcs_mode_t   mode_r;
  logic [1:0]  scl_sy_r;
  logic [1:0]  sda_sy_r;
  logic        sda_prev_r;
  logic [4:0]  req_r;
  logic        ack_val_r;
  logic [4:0]  req_clr_r;
  logic [7:0]  buf_r;
  logic [7:0]  shift_r;
  logic [7:0]  reload_r;
  logic [BW-1:0] cnt_r;
  logic        run_r;
  logic [3:0]  bits_r;
  logic        scl_low_r;
  logic        sda_low_r;
  logic        write_collision_flag_r;
  logic        bcol_r;
  logic        event_r;
  logic        sseen_r;
  logic        ackstat_r;
  logic        set_bcol_r;
  logic        set_event_r;
  logic        set_sseen_r;
  logic        set_ackst_r;
  logic        ackst_val_r;
  logic        rx_load_r;
  logic        tx_go_r;
  logic        scl_s;
  logic        sda_s;
  logic        tmo;
  logic        busy;
  logic        wr_buf;
  logic        wr_stat;
  logic        start_det;
  logic [3:0]  bit_last;

  // Two-stage synchronisers; only the second stage feeds logic
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      scl_sy_r   <= 2'h3;
      sda_sy_r   <= 2'h3;
      sda_prev_r <= 1'b1;
    end else begin
      scl_sy_r   <= {scl_sy_r[0], scl_i};
      sda_sy_r   <= {sda_sy_r[0], sda_i};
      sda_prev_r <= sda_sy_r[1];
    end
  end

  assign scl_s     = scl_sy_r[1];
  assign sda_s     = sda_sy_r[1];
  assign tmo       = run_r && (cnt_r == '0);
  assign busy      = (state_r != HCS_IDLE) || (req_r != 5'h00);
  assign wr_buf    = wr_i && (addr_i == `HCS_ADDR_BUF);
  assign wr_stat   = wr_i && (addr_i == `HCS_ADDR_STATUS);
  // Generated Starts are flagged by the sequencer, generated Repeated Starts by the detector
  assign start_det = scl_s && sda_prev_r && !sda_s &&
                     (state_r != HCS_ST_WAIT) && (state_r != HCS_ST_HOLD);

  // Open-drain pins: only ever pull low
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = scl_low_r;
  assign sda_oe_o = sda_low_r;

  // Request bits; new requests only while nothing is pending or running
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      req_r     <= 5'h00;
      ack_val_r <= 1'b0;
    end else begin
      if (wr_i && addr_i == `HCS_ADDR_CTRL2) begin
        ack_val_r <= wdata_i[`HCS_C_ACKVAL];
      end
      if (wr_i && addr_i == `HCS_ADDR_CTRL2 && !busy) begin
        req_r <= wdata_i[4:0] & `HCS_REQ_MASK;
      end else begin
        req_r <= req_r & ~req_clr_r;
      end
    end
  end

  // Buffer, reload value; a buffer write while busy is dropped, a reload write is not
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      buf_r    <= 8'h00;
      reload_r <= `HCS_RELOAD_RST;
      tx_go_r  <= 1'b0;
    end else begin
      tx_go_r <= 1'b0;
      if (wr_i && addr_i == `HCS_ADDR_RELOAD) begin
        reload_r <= wdata_i;
      end
      if (rx_load_r) begin
        buf_r <= shift_r;
      end else if (wr_buf && !busy && !tx_go_r) begin
        buf_r   <= wdata_i;
        tx_go_r <= 1'b1;
      end
    end
  end

  // Sticky status flags; a set in the clearing cycle wins
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      write_collision_flag_r    <= 1'b0;
      bcol_r    <= 1'b0;
      event_r   <= 1'b0;
      sseen_r   <= 1'b0;
      ackstat_r <= 1'b0;
    end else begin
      if (wr_buf && (busy || tx_go_r)) begin
        write_collision_flag_r <= 1'b1;
      end else if (wr_stat && wdata_i[`HCS_S_WRITE_COLLISION_FLAG]) begin
        write_collision_flag_r <= 1'b0;
      end
      if (set_bcol_r) begin
        bcol_r <= 1'b1;
      end else if (wr_stat && wdata_i[`HCS_S_BCOL]) begin
        bcol_r <= 1'b0;
      end
      if (set_event_r) begin
        event_r <= 1'b1;
      end else if (wr_stat && wdata_i[`HCS_S_EVENT]) begin
        event_r <= 1'b0;
      end
      if (set_sseen_r || start_det) begin
        sseen_r <= 1'b1;
      end else if (wr_stat && wdata_i[`HCS_S_SSEEN]) begin
        sseen_r <= 1'b0;
      end
      if (set_ackst_r) begin
        ackstat_r <= ackst_val_r;
      end
    end
  end

  // Read data stands in the cycle after the read strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `HCS_ADDR_CTRL2:  rdata_o <= {2'h0, ack_val_r, req_r};
        `HCS_ADDR_STATUS: rdata_o <= {2'h0, busy, ackstat_r, sseen_r,
                                      event_r, bcol_r, write_collision_flag_r};
        `HCS_ADDR_BUF:    rdata_o <= buf_r;
        default:          rdata_o <= reload_r;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  always_comb begin
    case (mode_r)
      HCS_M_TX: bit_last = `HCS_TX_BITS;
      HCS_M_RX: bit_last = `HCS_RX_BITS;
      default:  bit_last = `HCS_ACK_BITS;
    endcase
  end

  // Sequencer with its down-counting baud generator
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r     <= HCS_IDLE;
      mode_r      <= HCS_M_TX;
      cnt_r       <= '0;
      run_r       <= 1'b0;
      bits_r      <= 4'h0;
      shift_r     <= 8'h00;
      scl_low_r   <= 1'b0;
      sda_low_r   <= 1'b0;
      req_clr_r   <= 5'h00;
      set_bcol_r  <= 1'b0;
      set_event_r <= 1'b0;
      set_sseen_r <= 1'b0;
      set_ackst_r <= 1'b0;
      ackst_val_r <= 1'b0;
      rx_load_r   <= 1'b0;
    end else begin
      req_clr_r   <= 5'h00;
      set_bcol_r  <= 1'b0;
      set_event_r <= 1'b0;
      set_sseen_r <= 1'b0;
      set_ackst_r <= 1'b0;
      rx_load_r   <= 1'b0;
      if (run_r && cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
      case (state_r)
        HCS_IDLE: begin
          run_r <= 1'b0;
          if (req_clr_r != 5'h00) begin
            // Wait for the request bit to clear before looking again
          end else if (req_r[`HCS_C_START]) begin
            if (!scl_s && !sda_s) begin
              set_bcol_r <= 1'b1;
              req_clr_r  <= 5'h1f;
            end else if (scl_s && sda_s) begin
              cnt_r   <= reload_r[BW-1:0];
              run_r   <= 1'b1;
              state_r <= HCS_ST_WAIT;
            end
          end else if (req_r[`HCS_C_RSTART]) begin
            scl_low_r <= 1'b1;
            state_r   <= HCS_RS_LOW;
          end else if (req_r[`HCS_C_RCV] || req_r[`HCS_C_ACKREQ] || tx_go_r) begin
            mode_r    <= req_r[`HCS_C_RCV] ? HCS_M_RX :
                         req_r[`HCS_C_ACKREQ] ? HCS_M_ACK : HCS_M_TX;
            shift_r   <= buf_r;
            bits_r    <= 4'h0;
            scl_low_r <= 1'b1;
            sda_low_r <= req_r[`HCS_C_RCV] ? 1'b0 :
                         req_r[`HCS_C_ACKREQ] ? !ack_val_r : !buf_r[7];
            cnt_r     <= reload_r[BW-1:0];
            run_r     <= 1'b1;
            state_r   <= HCS_B_LOW;
          end
        end
        HCS_ST_WAIT: begin
          if (!scl_s) begin
            set_bcol_r <= 1'b1;
            req_clr_r  <= 5'h1f;
            state_r    <= HCS_IDLE;
          end else if (tmo) begin
            sda_low_r   <= 1'b1;
            set_sseen_r <= 1'b1;
            cnt_r       <= reload_r[BW-1:0];
            state_r     <= HCS_ST_HOLD;
          end
        end
        HCS_ST_HOLD: begin
          if (tmo) begin
            run_r       <= 1'b0;
            req_clr_r   <= 5'h01;
            set_event_r <= 1'b1;
            state_r     <= HCS_IDLE;
          end
        end
        HCS_RS_LOW: begin
          if (!scl_s) begin
            sda_low_r <= 1'b0;
            cnt_r     <= reload_r[BW-1:0];
            run_r     <= 1'b1;
            state_r   <= HCS_RS_SDA;
          end
        end
        HCS_RS_SDA: begin
          if (tmo && sda_s) begin
            scl_low_r <= 1'b0;
            run_r     <= 1'b0;
            state_r   <= HCS_RS_SCLH;
          end
        end
        HCS_RS_SCLH: begin
          if (scl_s && !sda_s) begin
            set_bcol_r <= 1'b1;
            req_clr_r  <= 5'h1f;
            state_r    <= HCS_IDLE;
          end else if (scl_s) begin
            cnt_r   <= reload_r[BW-1:0];
            run_r   <= 1'b1;
            state_r <= HCS_RS_HIGH;
          end
        end
        HCS_RS_HIGH: begin
          if (!scl_s) begin
            set_bcol_r <= 1'b1;
            req_clr_r  <= 5'h1f;
            state_r    <= HCS_IDLE;
          end else if (tmo) begin
            sda_low_r <= 1'b1;
            cnt_r     <= reload_r[BW-1:0];
            state_r   <= HCS_RS_SDAL;
          end
        end
        HCS_RS_SDAL: begin
          if (tmo) begin
            scl_low_r   <= 1'b1;
            run_r       <= 1'b0;
            req_clr_r   <= 5'h02;
            set_event_r <= 1'b1;
            state_r     <= HCS_IDLE;
          end
        end
        HCS_B_LOW: begin
          if (tmo) begin
            scl_low_r <= 1'b0;
            run_r     <= 1'b0;
            state_r   <= HCS_B_REL;
          end
        end
        HCS_B_REL: begin
          if (scl_s) begin
            cnt_r   <= reload_r[BW-1:0];
            run_r   <= 1'b1;
            state_r <= HCS_B_HIGH;
          end
        end
        HCS_B_HIGH: begin
          if (tmo) begin
            scl_low_r <= 1'b1;
            bits_r    <= bits_r + 4'h1;
            if (mode_r != HCS_M_ACK) begin
              shift_r <= {shift_r[6:0], sda_s};
            end
            if (bits_r + 4'h1 == bit_last) begin
              run_r       <= 1'b0;
              set_event_r <= 1'b1;
              state_r     <= HCS_IDLE;
              case (mode_r)
                HCS_M_TX: begin
                  set_ackst_r <= 1'b1;
                  ackst_val_r <= sda_s;
                end
                HCS_M_RX: begin
                  rx_load_r <= 1'b1;
                  req_clr_r <= 5'h08;
                end
                default: begin
                  sda_low_r <= 1'b0;
                  req_clr_r <= 5'h10;
                end
              endcase
            end else begin
              // Ninth bit of a transmit and all receive bits leave data free
              sda_low_r <= (mode_r == HCS_M_TX) && (bits_r + 4'h1 < 4'h8) &&
                           !shift_r[6];
              cnt_r     <= reload_r[BW-1:0];
              state_r   <= HCS_B_LOW;
            end
          end
        end
        default: begin
          state_r <= HCS_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: dv/hcs_seq_properties.sv */
`timescale 1ns/1ps
`include "hcs_cfg.svh"
module hcs_seq_properties (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       scl_i,
  input wire logic       scl_oe_o,
  input wire logic       sda_i,
  input wire logic       sda_oe_o
);
  logic       w_ctl;
  logic       w_buf;
  logic [7:0] reload_r;
  logic [7:0] hi_r;
  logic [7:0] lo_r;
  logic       ackv_r;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Decoded writes
  assign w_ctl = wr_i && (addr_i == `HCS_ADDR_CTRL2);
  assign w_buf = wr_i && (addr_i == `HCS_ADDR_BUF);
  // Shadow of reload and ack value, so phase checks follow software
  always_ff @(posedge clock_i) begin
    if (rst_i) reload_r <= `HCS_RELOAD_RST;
    else if (wr_i && addr_i == `HCS_ADDR_RELOAD) reload_r <= wdata_i;
  end
  always_ff @(posedge clock_i) begin
    if (w_ctl) ackv_r <= wdata_i[`HCS_C_ACKVAL];
  end
  // Phase counters; bounds stay loose by the two synchroniser stages
  always_ff @(posedge clock_i) begin
    if (rst_i || scl_oe_o || !scl_i) hi_r <= 8'h00;
    else if (hi_r != 8'hff) hi_r <= hi_r + 8'h01;
  end
  always_ff @(posedge clock_i) begin
    if (rst_i || !scl_oe_o) lo_r <= 8'h00;
    else if (lo_r != 8'hff) lo_r <= lo_r + 8'h01;
  end
  sequence s_start_high;
    w_ctl && wdata_i[`HCS_C_START] && scl_i && sda_i && !scl_oe_o;
  endsequence
  sequence s_start_low;
    w_ctl && wdata_i[`HCS_C_START] && !scl_i && !sda_i ##1 (!scl_i && !sda_i) [*4];
  endsequence
  sequence s_buf_twice;
    w_buf ##1 w_buf;
  endsequence
  a_reload_readback: assert property (
    rd_i && addr_i == `HCS_ADDR_RELOAD |=> rdata_o == reload_r)
    else $error("reload readback wrong");
  a_scl_high_min: assert property (
    $rose(scl_oe_o) |-> hi_r >= reload_r)
    else $error("clock high phase too short");
  a_scl_low_min: assert property (
    $fell(scl_oe_o) |-> lo_r >= reload_r)
    else $error("clock low phase too short");
  a_write_collision_flag_back2back: assert property (
    s_buf_twice ##1 (rd_i && addr_i == `HCS_ADDR_STATUS) |=> rdata_o[`HCS_S_WRITE_COLLISION_FLAG])
    else $error("write collision not flagged");
  a_start_sda_hold: assert property (
    $rose(sda_oe_o) && !scl_oe_o |-> !scl_oe_o [*4])
    else $error("clock pulled too soon after data low");
  a_bcol_no_drive: assert property (
    s_start_low |=> !sda_oe_o [*4])
    else $error("start driven on a busy bus");
  a_ack_presents: assert property (
    w_ctl && wdata_i[`HCS_C_ACKREQ] && !$past(wr_i) |=> ##[0:3] (scl_oe_o && sda_oe_o == !ackv_r))
    else $error("ack value not presented");
  a_ctrl_locked_start: assert property (
    s_start_high ##1 (w_ctl && wdata_i[`HCS_C_ACKREQ]) |-> !scl_oe_o [*8] ##1 !scl_oe_o [*8])
    else $error("request taken during start");
endmodule

/* File: dv/hcs_client_model.sv */
`timescale 1ns/1ps
module hcs_client_model (
  input  wire logic       clock_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       ack_en_i,
  input  wire logic       jam_i,
  input  wire logic [3:0] stretch_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            scl_dn_o,
  output logic            sda_dn_o,
  output logic [7:0]      got_o,
  output logic            host_ack_o,
  output logic [3:0]      starts_o
);
  logic       scl_q, sda_q, reads, first, drv;
  logic [3:0] bits, hold;
  logic [7:0] sh;
  logic [2:0] bi;
  // Lines idle high until the host frames a transfer
  initial begin
    {scl_q, sda_q, reads, first, drv, host_ack_o} = 6'h30;
    {bits, hold, starts_o} = 12'h000;
    {sh, got_o} = 16'h0000;
  end
  assign bi = (bits == 4'h9) ? 3'h7 : 3'(4'h7 - bits);
  // Stretch holds the clock past the host's low phase; jam pins both lines
  assign scl_dn_o = (hold != 4'h0) || jam_i;
  assign sda_dn_o = drv || jam_i;
  always @(posedge clock_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    hold  <= (scl_q && !scl_i) ? stretch_i : ((hold != 4'h0) ? hold - 4'h1 : 4'h0);
    if (scl_i && sda_q && !sda_i) begin // start or repeated start
      starts_o <= starts_o + 4'h1;
      bits     <= 4'h0;
      first    <= 1'b1;
      reads    <= 1'b0;
      drv      <= 1'b0;
    end else if (!scl_q && scl_i) begin
      if (bits < 4'h8) sh <= {sh[6:0], sda_i};
      else host_ack_o <= sda_i;
      bits <= bits + 4'h1;
    end else if (scl_q && !scl_i) begin
      if (bits == 4'h8) begin
        got_o <= sh;
        first <= 1'b0;
        if (first) reads <= sh[0];
        drv <= ack_en_i && (first || !reads);
      end else begin
        bits <= (bits == 4'h9) ? 4'h0 : bits;
        drv  <= reads && !host_ack_o && !tx_byte_i[bi];
      end
    end
  end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
`include "hcs_cfg.svh"
module tb;
  localparam logic [1:0] CT = `HCS_ADDR_CTRL2;
  localparam logic [1:0] ST = `HCS_ADDR_STATUS;
  localparam logic [1:0] BF = `HCS_ADDR_BUF;
  localparam logic [1:0] RL = `HCS_ADDR_RELOAD;
  logic       clock_i, rst_i, wr_i, rd_i, jam;
  logic [1:0] addr_i;
  logic [7:0] wdata_i, rdata_o, last_rd, got;
  logic       scl_oe, sda_oe, scl_dn, sda_dn, scl_w, sda_w, host_ack;
  logic       scl_lvl, sda_lvl;
  logic [3:0] stretch, starts;
  int         n_errors, cmp_count;
  // Wired-AND bus with pull-ups; an enabled pin shows its output level, so a wrong level breaks the bus
  assign scl_w = !((scl_oe && !scl_lvl) || scl_dn);
  assign sda_w = !((sda_oe && !sda_lvl) || sda_dn);
  hcs_sequencer #(.BW(8)) u_hcs_sequencer (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w), .scl_o(scl_lvl),
    .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_lvl), .sda_oe_o(sda_oe));
  hcs_client_model u_hcs_client_model (
    .clock_i(clock_i), .scl_i(scl_w), .sda_i(sda_w), .ack_en_i(1'b1),
    .jam_i(jam), .stretch_i(stretch), .tx_byte_i(8'h3c), .scl_dn_o(scl_dn),
    .sda_dn_o(sda_dn), .got_o(got), .host_ack_o(host_ack), .starts_o(starts));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Keep leaves the strobe up so a second write follows with no gap
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input bit keep = 1'b0);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    if (!keep) begin
      wr_i <= 1'b0;
      @(posedge clock_i);
    end
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] m = 8'h00, input logic [7:0] e = 8'h00);
    wr_i   <= 1'b0;
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 last_rd = rdata_o;
    @(posedge clock_i);
    if (m != 8'h00) chk(last_rd & m, e);
  endtask
  task automatic poll(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while ((last_rd & m) !== e && n < 3000);
    chk(last_rd & m, e);
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Whole sequence needs well under 20000 cycles
  initial begin
    repeat (40000) @(posedge clock_i);
    n_errors++;
    $display("BAD t=%0t watchdog", $time);
    test_done();
  end
  initial begin
    {rst_i, wr_i, rd_i, jam} = 4'h8;
    addr_i    = 2'h0;
    wdata_i   = 8'h00;
    stretch   = 4'h0;
    n_errors  = 0;
    cmp_count = 0;
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(RL, 8'hff, 8'h04);
    rd(ST, 8'hff, 8'h00);
    rd(CT, 8'hff, 8'h00);
    wr(RL, 8'h03);
    rd(RL, 8'hff, 8'h03);
    wr(CT, 8'h01, 1'b1);
    wr(CT, 8'h10);
    rd(CT, 8'hff, 8'h01);
    poll(CT, 8'hff, 8'h00);
    chk({4'h0, starts}, 8'h01);
    rd(ST, 8'h0c, 8'h0c);
    wr(ST, 8'hff);
    wr(BF, 8'ha4, 1'b1);
    wr(BF, 8'h55, 1'b1);
    rd(ST, 8'hff, 8'h21);
    poll(ST, 8'h04, 8'h04);
    chk(got, 8'ha4);
    rd(ST, 8'h10, 8'h00);
    rd(BF, 8'hff, 8'ha4);
    wr(ST, 8'hff);
    wr(CT, 8'h02);
    poll(CT, 8'h02, 8'h00);
    chk({4'h0, starts}, 8'h02);
    rd(ST, 8'h0c, 8'h0c);
    wr(ST, 8'hff);
    stretch <= 4'hc;
    wr(BF, 8'ha5);
    poll(ST, 8'h04, 8'h04);
    chk(got, 8'ha5);
    wr(ST, 8'hff);
    wr(CT, 8'h08, 1'b1);
    wr(CT, 8'h02);
    poll(CT, 8'h0a, 8'h00);
    chk({4'h0, starts}, 8'h02);
    rd(BF, 8'hff, 8'h3c);
    wr(ST, 8'hff);
    wr(CT, 8'h20);
    wr(CT, 8'h30, 1'b1);
    wr(BF, 8'h77);
    poll(CT, 8'h10, 8'h00);
    chk({7'h0, host_ack}, 8'h01);
    rd(ST, 8'h05, 8'h05);
    rd(BF, 8'hff, 8'h3c);
    jam <= 1'b1;
    repeat (3) @(posedge clock_i);
    wr(CT, 8'h01);
    poll(CT, 8'h1f, 8'h00);
    rd(ST, 8'h02, 8'h02);
    jam <= 1'b0;
    test_done();
  end
endmodule
bind hcs_sequencer hcs_seq_properties u_hcs_seq_properties (
  .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_i),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_oe_o(sda_oe_o));
